// file: serial_frame_baud.sv
// serial transceiver with frame format and baud divisor control
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - transmit one stop bit, or two when set
// - receiver ignores stop count select
// - char size code gives 5..9 data bits
// - polarity picks sync transmit and sample edges
// - divisor high view reads select as zero
// - divisor is twelve bits, high plus low
// - low write reloads prescaler at once
// - frame format shares location, select one
// - double speed divides by eight not sixteen
// - sync mode select: zero async, one sync
module serial_frame_baud (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // avalon-mm slave
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // serial pins
    input wire logic RXD,
    output logic TXD,
    output logic TXD_OE,
    output logic XCK_O,
    output logic XCK_OE
);
    ////////////////////////////////////////////////////////////////////////////
    logic rst_a, rst_n;  // reset release chain
    serial_cfg_pkg::frame_format_t frame;  // frame format register
    logic [3:0] div_high;  // divisor upper bits
    logic [7:0] div_low;  // divisor lower bits
    logic [4:0] control;  // enables, size bit2, double speed, view
    logic ack;  // answer cycle of a bus access
    logic [11:0] presc;  // baud prescaler
    logic sync_serial_clock;  // sync serial clock level
    logic rx1, rx2, rx3, rxd;  // receive line synchroniser and filtered level
    logic [8:0] rx_data;  // received character
    logic rx_valid, frame_err;  // character waiting, its stop bit was low
    logic tx_busy;  // frame in progress
    // reset released through two flip-flops
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_a <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_a <= 1'b1;
            rst_n <= rst_a;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    wire req = AVS_READ | AVS_WRITE;
    wire hit_shared = (AVS_ADDRESS == serial_cfg_pkg::OFS_SHARED);
    wire hit_low = (AVS_ADDRESS == serial_cfg_pkg::OFS_DIV_LOW);
    wire hit_ctl = (AVS_ADDRESS == serial_cfg_pkg::OFS_CONTROL);
    wire hit_data = (AVS_ADDRESS == serial_cfg_pkg::OFS_DATA);
    wire hit_stat = (AVS_ADDRESS == serial_cfg_pkg::OFS_STATUS);
    wire fifo_in_ready;
    wire stall = AVS_WRITE & hit_data & !fifo_in_ready;  // full fifo holds the master
    wire wr_fire = AVS_WRITE & ack;
    wire rd_fire = AVS_READ & ack;
    wire sel_w = AVS_WRITEDATA[serial_cfg_pkg::SEL_BIT];
    wire wr_frame = wr_fire & hit_shared & sel_w;
    wire wr_high = wr_fire & hit_shared & !sel_w;
    wire wr_low = wr_fire & hit_low;
    wire push = wr_fire & hit_data;
    wire pop_rx = rd_fire & hit_data;
    assign AVS_WAITREQUEST = req & !ack;
    // control fields
    wire tx_en = control[serial_cfg_pkg::CTL_TX_EN];
    wire rx_en = control[serial_cfg_pkg::CTL_RX_EN];
    wire dbl = control[serial_cfg_pkg::CTL_DOUBLE];
    wire view_frame = control[serial_cfg_pkg::CTL_VIEW];
    wire sync = frame.sync_mode_select;
    wire [11:0] divisor = {div_high, div_low};
    // read views of the shared location
    wire [7:0] high_view = {1'b0, 3'h0, div_high};
    wire [7:0] frame_view = {1'b1, frame[6:0]};
    wire [7:0] shared_view = view_frame ? frame_view : high_view;
    wire [4:0] fifo_stat;
    wire [31:0] rd_mux = hit_shared ? {24'h0, shared_view} :
                         hit_low ? {24'h0, div_low} :
                         hit_ctl ? {27'h0, control} :
                         hit_data ? {23'h0, rx_data} :
                         hit_stat ? {27'h0, fifo_stat} : 32'h0;
    // one wait cycle per access, longer while the fifo is full
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
            AVS_READDATA <= 32'h0;
        end else begin
            ack <= req & !ack & !stall;
            if (AVS_READ & !ack) begin
                AVS_READDATA <= rd_mux;
            end
        end
    end
    // configuration registers
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            frame <= serial_cfg_pkg::FRAME_RESET;
            div_high <= serial_cfg_pkg::DIV_HIGH_RESET;
            div_low <= serial_cfg_pkg::DIV_LOW_RESET;
            control <= serial_cfg_pkg::CONTROL_RESET;
        end else begin
            if (wr_frame) begin
                frame <= AVS_WRITEDATA[7:0];
            end
            if (wr_high) begin
                div_high <= AVS_WRITEDATA[3:0];
            end
            if (wr_low) begin
                div_low <= AVS_WRITEDATA[7:0];
            end
            if (wr_fire & hit_ctl) begin
                control <= AVS_WRITEDATA[4:0];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // character size decode, reserved codes fall back to eight
    wire [2:0] size_code = {control[serial_cfg_pkg::CTL_SIZE2], frame.char_size_bit1, frame.char_size_bit0};
    logic [3:0] nbits;
    always_comb begin
        case (size_code)
            3'h0: nbits = 4'h5;
            3'h1: nbits = 4'h6;
            3'h2: nbits = 4'h7;
            3'h7: nbits = 4'h9;
            default: nbits = 4'h8;
        endcase
    end
    // prescaler, one tick every divisor plus one cycles
    wire tick = (presc == 12'h000);
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            presc <= 12'h000;
            sync_serial_clock <= 1'b0;
        end else begin
            if (wr_low) begin
                presc <= {div_high, AVS_WRITEDATA[7:0]};
            end else if (tick) begin
                presc <= divisor;
            end else begin
                presc <= presc - 1'b1;
            end
            if (tick & sync) begin
                sync_serial_clock <= !sync_serial_clock;
            end else if (!sync) begin
                sync_serial_clock <= frame.sync_clock_polarity;
            end
        end
    end
    // sync edges, polarity zero shifts on rising and samples on falling
    wire sync_tx_edge = sync & tick & (sync_serial_clock == frame.sync_clock_polarity);
    wire sync_rx_edge = sync & tick & (sync_serial_clock != frame.sync_clock_polarity);
    wire [3:0] ovs_last = dbl ? serial_cfg_pkg::OVS_DOUBLE_LAST : serial_cfg_pkg::OVS_NORMAL_LAST;
    wire [3:0] half_last = dbl ? serial_cfg_pkg::HALF_DOUBLE_LAST : serial_cfg_pkg::HALF_NORMAL_LAST;
    assign XCK_O = sync_serial_clock;
    assign XCK_OE = sync & tx_en;
    ////////////////////////////////////////////////////////////////////////////
    // transmit fifo and shifter
    wire fifo_out_valid;
    wire [8:0] fifo_out_data;
    logic tx_pop;
    serial_fifo #(
        .WIDTH(serial_cfg_pkg::FIFO_WIDTH),
        .DEPTH(serial_cfg_pkg::FIFO_DEPTH)
    ) tx_fifo (
        .clk(CLK),
        .rst_n(rst_n),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(AVS_WRITEDATA[8:0]),
        .out_valid(fifo_out_valid),
        .out_ready(tx_pop),
        .out_data(fifo_out_data)
    );
    assign fifo_stat = {tx_busy, !fifo_in_ready, !fifo_out_valid, frame_err, rx_valid};
    typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_STOP} tx_state_t;
    tx_state_t tx_state;
    logic [3:0] tx_sub, tx_cnt;  // async oversample count, data bits sent
    logic [8:0] tx_sh;  // data shifter
    logic tx_stop_left;  // second stop bit pending
    wire tx_bit = sync ? sync_tx_edge : (tick & (tx_sub == ovs_last));
    assign tx_pop = tx_bit & (tx_state == TX_IDLE) & tx_en & fifo_out_valid;
    assign TXD_OE = tx_en;
    assign tx_busy = (tx_state != TX_IDLE);
    // async bit timing
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            tx_sub <= 4'h0;
        end else if (tick) begin
            tx_sub <= (tx_sub >= ovs_last) ? 4'h0 : tx_sub + 1'b1;
        end
    end
    // frame sequence: start, data lsb first, stop bits
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            tx_state <= TX_IDLE;
            TXD <= 1'b1;
            tx_sh <= 9'h000;
            tx_cnt <= 4'h0;
            tx_stop_left <= 1'b0;
        end else if (tx_bit) begin
            case (tx_state)
                TX_IDLE: begin
                    TXD <= 1'b1;
                    if (tx_pop) begin
                        TXD <= 1'b0;  // start bit
                        tx_sh <= fifo_out_data;
                        tx_cnt <= 4'h0;
                        tx_state <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    TXD <= tx_sh[0];
                    tx_sh <= {1'b0, tx_sh[8:1]};
                    tx_cnt <= tx_cnt + 1'b1;
                    if (tx_cnt == nbits - 1'b1) begin
                        tx_state <= TX_STOP;
                        tx_stop_left <= frame.stop_count_select;
                    end
                end
                TX_STOP: begin
                    TXD <= 1'b1;
                    if (tx_stop_left) begin
                        tx_stop_left <= 1'b0;
                    end else begin
                        tx_state <= TX_IDLE;
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // receive line synchroniser, level changes once stages two and three agree
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rx1 <= 1'b1;
            rx2 <= 1'b1;
            rx3 <= 1'b1;
            rxd <= 1'b1;
        end else begin
            rx1 <= RXD;
            rx2 <= rx1;
            rx3 <= rx2;
            if (rx2 == rx3) begin
                rxd <= rx3;
            end
        end
    end
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
    rx_state_t rx_state;
    logic [3:0] rx_sub, rx_cnt;  // oversample count, data bits taken
    logic [8:0] rx_sh;  // incoming shifter
    logic rx_done, rx_ferr;  // character complete this cycle, its stop bit was low
    wire rx_bit = sync ? sync_rx_edge : (tick & (rx_sub == ovs_last));
    wire [8:0] rx_aligned = rx_sh >> (4'h9 - nbits);
    // receiver, stop count select never consulted
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rx_state <= RX_IDLE;
            rx_sub <= 4'h0;
            rx_cnt <= 4'h0;
            rx_sh <= 9'h000;
            rx_done <= 1'b0;
            rx_ferr <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (tick & (rx_state != RX_IDLE)) begin
                rx_sub <= (rx_sub >= ovs_last) ? 4'h0 : rx_sub + 1'b1;
            end
            case (rx_state)
                RX_IDLE: begin
                    rx_sub <= 4'h0;
                    rx_cnt <= 4'h0;
                    if (rx_en & sync & sync_rx_edge & !rxd) begin
                        rx_state <= RX_DATA;
                    end else if (rx_en & !sync & !rxd) begin
                        rx_state <= RX_START;
                    end
                end
                RX_START: begin
                    if (tick & (rx_sub == half_last)) begin
                        rx_sub <= 4'h0;  // realign to bit centre
                        rx_state <= rxd ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_bit) begin
                        rx_sh <= {rxd, rx_sh[8:1]};
                        rx_cnt <= rx_cnt + 1'b1;
                        if (rx_cnt == nbits - 1'b1) begin
                            rx_state <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_bit) begin
                        rx_ferr <= !rxd;  // only the first stop bit is checked
                        rx_done <= 1'b1;
                        rx_state <= RX_IDLE;
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end
    // receive holding register, a new character wins over a read
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rx_data <= 9'h000;
            rx_valid <= 1'b0;
            frame_err <= 1'b0;
        end else if (rx_done) begin
            rx_data <= rx_aligned;
            rx_valid <= 1'b1;
            frame_err <= rx_ferr;
        end else if (pop_rx | !rx_en) begin
            rx_valid <= 1'b0;
            frame_err <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: serial_cfg_pkg.sv
// constants, register map and field layout of the serial frame and baud block
`default_nettype none
package serial_cfg_pkg;
    // register byte offsets on the avalon slave
    localparam logic [4:0] OFS_SHARED = 5'h00;
    localparam logic [4:0] OFS_DIV_LOW = 5'h04;
    localparam logic [4:0] OFS_CONTROL = 5'h08;
    localparam logic [4:0] OFS_DATA = 5'h0C;
    localparam logic [4:0] OFS_STATUS = 5'h10;
    // field positions
    localparam int SEL_BIT = 7;
    localparam int CTL_TX_EN = 0;
    localparam int CTL_RX_EN = 1;
    localparam int CTL_SIZE2 = 2;
    localparam int CTL_DOUBLE = 3;
    localparam int CTL_VIEW = 4;
    // reset values
    localparam logic [7:0] FRAME_RESET = 8'h86;
    localparam logic [3:0] DIV_HIGH_RESET = 4'h0;
    localparam logic [7:0] DIV_LOW_RESET = 8'h00;
    localparam logic [4:0] CONTROL_RESET = 5'h00;
    // oversampling counts, last index of each bit period and of each half bit period
    localparam logic [3:0] OVS_NORMAL_LAST = 4'hF;
    localparam logic [3:0] OVS_DOUBLE_LAST = 4'h7;
    localparam logic [3:0] HALF_NORMAL_LAST = 4'h7;
    localparam logic [3:0] HALF_DOUBLE_LAST = 4'h3;
    // fifo shape
    localparam int FIFO_WIDTH = 9;
    localparam int FIFO_DEPTH = 8;
    // frame format register layout
    typedef struct packed {
        logic sel;
        logic sync_mode_select;
        logic [1:0] parity_mode;
        logic stop_count_select;
        logic char_size_bit1;
        logic char_size_bit0;
        logic sync_clock_polarity;
    } frame_format_t;
endpackage
`default_nettype wire

// file: serial_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/10ps
`default_nettype none
module serial_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];  // storage
    logic [AW:0] wptr;  // write pointer with wrap bit
    logic [AW:0] rptr;  // read pointer with wrap bit
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    // full when pointers differ only in wrap bit
    assign in_ready = !((wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]));
    assign out_valid = (wptr != rptr);
    assign out_data = mem[rptr[AW-1:0]];
    // storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr[AW-1:0]] <= in_data;
        end
    end
    // pointer update
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr <= '0;
            rptr <= '0;
        end else begin
            if (push) begin
                wptr <= wptr + 1'b1;
            end
            if (pop) begin
                rptr <= rptr + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: serial_frame_baud_monitor.sv
// checker on the serial frame and baud block ports
`timescale 1ns/10ps
`default_nettype none
module serial_frame_baud_monitor (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // register bus
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    // serial pins
    input wire logic TXD,
    input wire logic TXD_OE,
    input wire logic XCK_O,
    input wire logic XCK_OE
);
    serial_cfg_pkg::frame_format_t frame; // shadow frame format
    logic [11:0] div; // shadow divisor
    logic [4:0] ctl; // shadow control
    int low_run; // cycles txd held low
    int xrun; // cycles since xck moved
    logic xok; // a whole xck half seen
    int bit_len; // expected bit period
    logic wr_t, rd_t, at_sh, unmapped; // decoded bus events
    assign wr_t = AVS_WRITE && !AVS_WAITREQUEST;
    assign rd_t = AVS_READ && !AVS_WAITREQUEST;
    assign at_sh = AVS_ADDRESS == serial_cfg_pkg::OFS_SHARED;
    assign unmapped = AVS_ADDRESS > serial_cfg_pkg::OFS_STATUS || AVS_ADDRESS[1:0] != 2'h0;
    assign bit_len = frame.sync_mode_select ? 2 * (div + 1) : (ctl[3] ? 8 : 16) * (div + 1);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    ////////////////////////////////////////////////////////////////
    // shadow registers follow taken writes
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            frame <= serial_cfg_pkg::FRAME_RESET;
            div <= 12'h000;
            ctl <= serial_cfg_pkg::CONTROL_RESET;
        end else if (wr_t) begin
            if (at_sh && AVS_WRITEDATA[7]) frame <= AVS_WRITEDATA[7:0];
            if (at_sh && !AVS_WRITEDATA[7]) div[11:8] <= AVS_WRITEDATA[3:0];
            if (AVS_ADDRESS == serial_cfg_pkg::OFS_DIV_LOW) div[7:0] <= AVS_WRITEDATA[7:0];
            if (AVS_ADDRESS == serial_cfg_pkg::OFS_CONTROL) ctl <= AVS_WRITEDATA[4:0];
        end
    end
    // run lengths of txd low and of each xck level
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            low_run <= 0;
            xrun <= 0;
            xok <= 1'b0;
        end else begin
            low_run <= TXD ? 0 : low_run + 1;
            xrun <= $changed(XCK_O) ? 1 : xrun + 1;
            xok <= wr_t ? 1'b0 : (($changed(XCK_O) && XCK_OE) ? 1'b1 : xok);
        end
    end
    ////////////////////////////////////////////////////////////////
    read_ack_a: assert property (AVS_READ && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("read not answered next cycle");
    idle_ready_a: assert property (!AVS_READ && !AVS_WRITE |-> !AVS_WAITREQUEST)
        else $error("waitrequest without request");
    shared_view_a: assert property (rd_t && at_sh |-> AVS_READDATA[7:0] ==
        (ctl[4] ? {1'b1, frame[6:0]} : {4'h0, div[11:8]})) else $error("shared location read wrong");
    unmapped_zero_a: assert property (rd_t && unmapped |-> AVS_READDATA == 32'h0)
        else $error("unmapped read not zero");
    tx_enable_a: assert property (TXD_OE == ctl[0]) else $error("txd enable wrong");
    xck_enable_a: assert property (XCK_OE == (frame.sync_mode_select && ctl[0]))
        else $error("xck enable wrong");
    bit_time_a: assert property ($rose(TXD) |-> low_run % bit_len == 0)
        else $error("low run not whole bits");
    xck_half_a: assert property (XCK_OE && xok && $changed(XCK_O) |-> xrun == div + 1)
        else $error("xck half period wrong");
    sync_edge_a: assert property (XCK_OE && $changed(TXD) |-> XCK_O != frame.sync_clock_polarity)
        else $error("txd moved on wrong xck edge");
endmodule
bind serial_frame_baud serial_frame_baud_monitor mon_u (.CLK, .RST_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .TXD, .TXD_OE, .XCK_O, .XCK_OE);
`default_nettype wire

// file: serial_peer.sv
// remote serial device on the transmit and receive lines
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
    // clock
    input wire logic clk,
    // line from the block and its shape
    input wire logic txd,
    input wire logic [15:0] bit_len,
    input wire logic [3:0] nbits,
    // line into the block
    output logic rxd
);
    logic [8:0] got_q[$]; // characters seen
    int stamp_q[$]; // cycle of each start edge
    int cyc = 0; // free cycle count
    logic [8:0] sh; // capture shift
    initial rxd = 1'b1; // idles high like a pulled-up line
    always @(posedge clk) cyc <= cyc + 1;
    // sample each frame mid bit, lsb first
    initial forever begin
        @(negedge txd);
        stamp_q.push_back(cyc);
        sh = 9'h000;
        repeat (bit_len / 2) @(posedge clk);
        for (int i = 0; i < nbits; i++) begin
            repeat (bit_len) @(posedge clk);
            sh[i] = txd;
        end
        repeat (bit_len) @(posedge clk);
        got_q.push_back(sh);
    end
    // send one character lsb first, then the stop bits
    task send(input logic [8:0] d, input int n, input int stops);
        rxd <= 1'b0;
        repeat (bit_len) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rxd <= d[i];
            repeat (bit_len) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (stops * bit_len) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking bench for the serial frame and baud block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam logic [4:0] SH = serial_cfg_pkg::OFS_SHARED;
    localparam logic [4:0] LW = serial_cfg_pkg::OFS_DIV_LOW;
    localparam logic [4:0] CT = serial_cfg_pkg::OFS_CONTROL;
    localparam logic [4:0] DT = serial_cfg_pkg::OFS_DATA;
    logic CLK, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, RXD, TXD, TXD_OE, XCK_O, XCK_OE;
    logic [4:0] AVS_ADDRESS;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
    logic [15:0] peer_bit; // peer bit period
    logic [3:0] peer_n; // peer data bits
    int errors = 0;
    int n_compared = 0;
    serial_frame_baud dut_u (.CLK, .RST_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
        .AVS_READDATA, .AVS_WAITREQUEST, .RXD, .TXD, .TXD_OE, .XCK_O, .XCK_OE);
    serial_peer peer_u (.clk(CLK), .txd(TXD), .bit_len(peer_bit), .nbits(peer_n), .rxd(RXD));
    ////////////////////////////////////////////////////////////////
    // compare and count
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // verdict and stop
    task end_sim;
        if (errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // one avalon access held until waitrequest low
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        // request stands until the rising edge that sees waitrequest low
        do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
        rd = AVS_READDATA;  // read data taken at that same edge
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask
    // poll a status bit until it reaches a level
    task wait_status(input int b, input logic lvl);
        for (int i = 0; i < 3000; i++) begin
            bus(1'b0, serial_cfg_pkg::OFS_STATUS, 32'h0);
            if (rd[b] === lvl) return;
        end
        check("status wait", rd[b], lvl);
    endtask
    ////////////////////////////////////////////////////////////////
    // shared location and divisor registers
    task t_regs;
        bus(1'b0, SH, 32'h0); check("divisor high view", rd, 32'h0);
        bus(1'b1, CT, 32'h10);
        bus(1'b0, SH, 32'h0); check("frame view", rd, 32'h86);
        bus(1'b1, SH, 32'h05);
        bus(1'b0, SH, 32'h0); check("frame kept", rd, 32'h86);
        bus(1'b1, CT, 32'h0);
        bus(1'b0, SH, 32'h0); check("divisor high", rd, 32'h05);
        bus(1'b1, LW, 32'h3C);
        bus(1'b0, LW, 32'h0); check("divisor low", rd, 32'h3C);
        bus(1'b1, SH, 32'h0);
        bus(1'b1, LW, 32'h0);
        bus(1'b1, 5'h14, 32'hFF);
        bus(1'b0, 5'h14, 32'h0); check("unmapped", rd, 32'h0);
    endtask
    // k frames sent back to back from the fifo
    task t_tx(input logic [2:0] code, input logic stop, input logic dbl, input int k);
        int n, gap;
        logic [8:0] d;
        n = (code == 3'b111) ? 9 : 5 + code[1:0];
        gap = (2 + n + stop) * (dbl ? 8 : 16);
        peer_bit <= dbl ? 16'h0008 : 16'h0010;
        peer_n <= n[3:0];
        bus(1'b1, SH, {24'h0, 4'b1000, stop, code[1:0], 1'b0});
        bus(1'b1, CT, {28'h0, dbl, code[2], 2'b01});
        peer_u.got_q.delete();
        peer_u.stamp_q.delete();
        for (int i = 0; i < k; i++) bus(1'b1, DT, 32'h0A5 + 37 * i);
        if (k > 9) begin
            bus(1'b0, serial_cfg_pkg::OFS_STATUS, 32'h0); check("fifo full", rd[3], 1'b1);
        end
        for (int i = 0; i < 4000 && peer_u.got_q.size() < k; i++) @(posedge CLK);
        for (int i = 0; i < k; i++) begin
            d = 9'h0A5 + 37 * i;
            check("sent char", peer_u.got_q[i], d & ((9'h001 << n) - 1));
            if (i > 0) check("frame spacing", peer_u.stamp_q[i] - peer_u.stamp_q[i - 1], gap);
        end
        wait_status(2, 1'b1);
        wait_status(4, 1'b0);
    endtask
    // two characters with one stop bit while two are selected
    task t_rx(input logic [2:0] code, input logic [8:0] a, input logic [8:0] b);
        int n;
        n = (code == 3'b111) ? 9 : 5 + code[1:0];
        peer_bit <= 16'h0010;
        bus(1'b1, SH, {24'h0, 4'b1000, 1'b1, code[1:0], 1'b0});
        bus(1'b1, CT, {29'h0, code[2], 2'b10});
        fork
            begin
                peer_u.send(a, n, 1);
                peer_u.send(b, n, 1);
            end
        join_none
        wait_status(0, 1'b1);
        check("frame error", rd[1], 1'b0);
        bus(1'b0, DT, 32'h0); check("received char", rd, a & ((9'h001 << n) - 1));
        wait_status(0, 1'b1);
        bus(1'b0, DT, 32'h0); check("received char", rd, b & ((9'h001 << n) - 1));
        wait fork;
    endtask
    // synchronous master frames at the polarity given by pol
    task t_sync(input logic pol);
        bus(1'b1, LW, 32'h3);
        bus(1'b1, SH, {24'h0, 5'b11000, 2'b11, pol});
        bus(1'b1, CT, 32'h1);
        @(negedge CLK);
        check("xck enable", XCK_OE, 1'b1);
        bus(1'b1, DT, 32'h5A);
        bus(1'b1, DT, 32'hC3);
        wait_status(2, 1'b1);
        wait_status(4, 1'b0);
        bus(1'b1, CT, 32'h0);
        bus(1'b1, SH, 32'h86);
        bus(1'b1, LW, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////
    // clock
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    // main sequence
    initial begin
        RST_N = 1'b0;
        AVS_READ = 1'b0;
        AVS_WRITE = 1'b0;
        AVS_ADDRESS = 5'h00;
        AVS_WRITEDATA = 32'h0;
        peer_bit = 16'h0010;
        peer_n = 4'h8;
        repeat (12) @(posedge CLK);
        check("line in reset", {TXD, TXD_OE}, 2'b10);
        RST_N <= 1'b1;
        repeat (3) @(posedge CLK);
        t_regs;
        t_tx(3'b000, 1'b0, 1'b0, 2);
        t_tx(3'b001, 1'b1, 1'b0, 2);
        t_tx(3'b010, 1'b0, 1'b1, 2);
        t_tx(3'b011, 1'b1, 1'b0, 10);
        t_tx(3'b111, 1'b1, 1'b1, 2);
        t_rx(3'b000, 9'h015, 9'h00A);
        t_rx(3'b111, 9'h1C3, 9'h03C);
        t_sync(1'b0);
        t_sync(1'b1);
        end_sim;
    end
    // watchdog against a hang
    initial begin
        repeat (60000) @(posedge CLK);
        errors++;
        end_sim;
    end
endmodule
`default_nettype wire
